// [rsb_reset_ctrl.sv]
// Reset source tracking, timed-access software reset and boot block select
`timescale 1ns/1ps

module rsb_reset_ctrl
  import rsb_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [7:0] HOLD_CYCLES = RESET_HOLD_CYCLES,
  parameter logic [7:0] TA_WINDOW = TA_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pc_overflow,
  input wire logic debug_running,
  input wire logic wdt_timeout,
  input wire logic ext_pin_reset,
  output logic system_reset,
  output logic wdt_clear,
  output logic boot_from_loader,
  output logic [15:0] reset_vector,
  output logic irq
);

  rsb_state_s q, d;

  // Map an aligned byte address onto one register, or none
  function automatic rsb_sel_e decode(input logic [ADDR_W-1:0] a);
    rsb_sel_e s;
    s = RSB_SEL_NONE;
    if (a[1:0] == 2'b00 && a[ADDR_W-1:10] == '0) begin
      case (a[9:2])
        IDX_CHIP_CONTROL: s = RSB_SEL_CC;
        IDX_AUX_FLAGS: s = RSB_SEL_AX;
        IDX_WATCHDOG_CONTROL: s = RSB_SEL_WD;
        IDX_BOOT_CONFIG: s = RSB_SEL_CFG;
        IDX_TIMED_ACCESS: s = RSB_SEL_TA;
        IDX_IRQ_STATUS: s = RSB_SEL_IST;
        IDX_IRQ_MASK: s = RSB_SEL_IMK;
        default: s = RSB_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  rsb_sel_e sel;
  logic wr_en;
  logic rd_setup;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic fault_reset;
  logic [EV_W-1:0] events;
  logic flag_only;

  // Zero-wait slave; error on unmapped words and on misaligned addresses
  assign sel = decode(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (sel == RSB_SEL_NONE);
  assign wr_en = psel & penable & pwrite & (sel != RSB_SEL_NONE);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];

  // Read view; write-only and strobe bits read zero
  always_comb begin
    rbyte = 8'h00;
    case (sel)
      RSB_SEL_CC: begin
        rbyte[CC_IAP_FAIL] = q.iap_fail;
        rbyte[CC_BOOT_SELECT] = q.boot_select;
        rbyte[CC_IAP_ENABLE] = q.iap_enable;
      end
      RSB_SEL_AX: begin
        rbyte[AX_SW_FLAG] = q.sw_flag;
        rbyte[AX_EXT_FLAG] = q.ext_flag;
        rbyte[AX_FAULT_FLAG] = q.fault_flag;
        rbyte[AX_GP_FLAG] = q.gp_flag;
        rbyte[AX_UART_SWAP] = q.uart_swap;
        rbyte[AX_DPTR_SEL] = q.dptr_sel;
      end
      RSB_SEL_WD: begin
        rbyte[WD_RUN] = q.wd_run;
        rbyte[WD_TIMEOUT_FLAG] = q.wd_timeout_flag;
        rbyte[WD_IDLE_PD] = q.wd_idle_pd;
        rbyte[WD_RESET_FLAG] = q.wd_reset_flag;
        rbyte[WD_PRESCALE_LSB +: WD_PRESCALE_W] = q.wd_prescale;
      end
      RSB_SEL_CFG: rbyte = q.config_byte;
      RSB_SEL_TA: rbyte = {7'h00, q.ta_open};
      RSB_SEL_IST: rbyte = {4'h0, q.irq_status};
      RSB_SEL_IMK: rbyte = {4'h0, q.irq_mask};
      default: rbyte = 8'h00;
    endcase
  end

  // Reset sources seen while running
  // debug bypass of fault reset
  assign flag_only = debug_running & ~q.config_byte[CFG_DEBUG_EN];
  assign fault_reset = pc_overflow & ~flag_only;
  assign events[EV_FAULT] = pc_overflow;
  assign events[EV_SW] = q.sw_trigger & (q.state == RSB_RUN);
  assign events[EV_WDT] = wdt_timeout;
  assign events[EV_EXT] = ext_pin_reset;

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    d.wdt_clear = 1'b0;

    // Timed-access window counts down and closes by itself
    if (q.ta_open) begin
      if (q.ta_cnt == 8'h00) begin
        d.ta_open = 1'b0;
      end else begin
        d.ta_cnt = q.ta_cnt - 8'h01;
      end
    end

    // Register writes; hardware sets below win over these
    if (wr_en) begin
      case (sel)
        RSB_SEL_TA: begin
          if (wbyte == TA_KEY_FIRST) begin
            d.ta_armed = 1'b1;
          end else if (wbyte == TA_KEY_SECOND && q.ta_armed) begin
            d.ta_armed = 1'b0;
            d.ta_open = 1'b1;
            d.ta_cnt = TA_WINDOW;
          end else begin
            d.ta_armed = 1'b0;
          end
        end
        RSB_SEL_CC: begin
          if (q.ta_open) begin
            d.ta_open = 1'b0;
            d.iap_fail = wbyte[CC_IAP_FAIL];
            d.boot_select = wbyte[CC_BOOT_SELECT];
            d.iap_enable = wbyte[CC_IAP_ENABLE];
            if (wbyte[CC_SW_RESET]) begin
              d.sw_trigger = 1'b1;
            end
          end
        end
        RSB_SEL_AX: begin
          // flags cleared or set by software
          d.sw_flag = wbyte[AX_SW_FLAG];
          d.ext_flag = wbyte[AX_EXT_FLAG];
          d.fault_flag = wbyte[AX_FAULT_FLAG];
          d.gp_flag = wbyte[AX_GP_FLAG];
          d.uart_swap = wbyte[AX_UART_SWAP];
          d.dptr_sel = wbyte[AX_DPTR_SEL];
        end
        RSB_SEL_WD: begin
          if (q.ta_open) begin
            d.ta_open = 1'b0;
            d.wd_run = wbyte[WD_RUN];
            d.wd_timeout_flag = wbyte[WD_TIMEOUT_FLAG];
            d.wd_idle_pd = wbyte[WD_IDLE_PD];
            d.wd_reset_flag = wbyte[WD_RESET_FLAG];
            d.wd_prescale = wbyte[WD_PRESCALE_LSB +: WD_PRESCALE_W];
            d.wdt_clear = wbyte[WD_CLEAR];
          end
        end
        RSB_SEL_CFG: d.config_byte = wbyte;
        RSB_SEL_IST: d.irq_status = q.irq_status & ~wbyte[EV_W-1:0];
        RSB_SEL_IMK: d.irq_mask = wbyte[EV_W-1:0];
        default: d.ta_armed = q.ta_armed;
      endcase
    end

    // Event capture; a same-cycle software clear loses
    d.irq_status = d.irq_status | events;
    // fault flag set on every overrun
    if (events[EV_FAULT]) begin
      d.fault_flag = 1'b1;
    end

    case (q.state)
      RSB_RUN: begin
        // Priority pin, watchdog, fault, software
        if (events[EV_EXT] || events[EV_WDT] || fault_reset || events[EV_SW]) begin
          d.state = RSB_HOLD;
          d.hold_cnt = HOLD_CYCLES;
          d.ta_open = 1'b0;
          d.ta_armed = 1'b0;
          if (events[EV_EXT]) begin
            d.cause = RSB_CAUSE_EXT;
            d.ext_flag = 1'b1;
          end else if (events[EV_WDT]) begin
            d.cause = RSB_CAUSE_WDT;
            d.wd_reset_flag = 1'b1;
          end else if (fault_reset) begin
            d.cause = RSB_CAUSE_FAULT;
          end else begin
            d.cause = RSB_CAUSE_SW;
            d.sw_flag = 1'b1;
          end
        end
      end
      RSB_HOLD: begin
        // Pin held high keeps the system in reset
        if (events[EV_EXT]) begin
          d.hold_cnt = HOLD_CYCLES;
        end else if (q.hold_cnt == 8'h00) begin
          d.state = RSB_RUN;
          d.sw_trigger = 1'b0;
          if (q.cause != RSB_CAUSE_SW) begin
            d.boot_select = ~q.config_byte[CFG_BOOT_BIT];
          end
        end else begin
          d.hold_cnt = q.hold_cnt - 8'h01;
        end
      end
      default: d.state = RSB_RUN;
    endcase

    // Read data latched in the setup cycle
    if (rd_setup) begin
      d.prdata = {24'h000000, rbyte};
    end
  end

  // State register; power-on clears the cause flags, warm resets keep them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q.state <= RSB_RUN;
      q.hold_cnt <= 8'h00;
      q.cause <= RSB_CAUSE_EXT;
      q.sw_trigger <= 1'b0;
      q.boot_select <= ~CFG_UNPROGRAMMED[CFG_BOOT_BIT];
      q.iap_fail <= 1'b0;
      q.iap_enable <= 1'b0;
      q.sw_flag <= 1'b0;
      q.ext_flag <= 1'b0;
      q.fault_flag <= 1'b0;
      q.gp_flag <= 1'b0;
      q.uart_swap <= 1'b0;
      q.dptr_sel <= 1'b0;
      q.wd_run <= 1'b0;
      q.wd_timeout_flag <= 1'b0;
      q.wd_idle_pd <= 1'b0;
      q.wd_reset_flag <= 1'b0;
      q.wd_prescale <= '0;
      q.config_byte <= CFG_UNPROGRAMMED;
      q.ta_armed <= 1'b0;
      q.ta_open <= 1'b0;
      q.ta_cnt <= 8'h00;
      q.irq_status <= '0;
      q.irq_mask <= '0;
      q.wdt_clear <= 1'b0;
      q.prdata <= 32'h00000000;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign prdata = q.prdata;
  // reset asserts on the second edge after the write
  assign system_reset = (q.state == RSB_HOLD);
  assign wdt_clear = q.wdt_clear;
  // boot select loaded from inverted config boot bit at the end of a non-software warm reset
  assign boot_from_loader = q.boot_select;
  assign reset_vector = RESET_VECTOR;
  assign irq = |(q.irq_status & q.irq_mask);

endmodule

// [rsb_pkg.sv]
// Constants, register map and types for the reset source and boot select block
package rsb_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHIP_CONTROL = 8'h9F;
  localparam logic [7:0] IDX_AUX_FLAGS = 8'hA2;
  localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hAA;
  localparam logic [7:0] IDX_BOOT_CONFIG = 8'hB0;
  localparam logic [7:0] IDX_TIMED_ACCESS = 8'hB1;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hB2;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hB3;

  // chip_control fields
  localparam int CC_SW_RESET = 7;
  localparam int CC_IAP_FAIL = 6;
  localparam int CC_BOOT_SELECT = 1;
  localparam int CC_IAP_ENABLE = 0;

  // auxiliary_reset_flags fields
  localparam int AX_SW_FLAG = 7;
  localparam int AX_EXT_FLAG = 6;
  localparam int AX_FAULT_FLAG = 5;
  localparam int AX_GP_FLAG = 3;
  localparam int AX_UART_SWAP = 2;
  localparam int AX_DPTR_SEL = 0;

  // watchdog_control fields
  localparam int WD_RUN = 7;
  localparam int WD_CLEAR = 6;
  localparam int WD_TIMEOUT_FLAG = 5;
  localparam int WD_IDLE_PD = 4;
  localparam int WD_RESET_FLAG = 3;
  localparam int WD_PRESCALE_LSB = 0;
  localparam int WD_PRESCALE_W = 3;

  // boot_configuration_byte fields
  localparam int CFG_BOOT_BIT = 7;
  localparam int CFG_DEBUG_EN = 4;
  localparam logic [7:0] CFG_UNPROGRAMMED = 8'hFF;

  // Timed-access unlock pattern
  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;

  // Event bits in irq status and mask
  localparam int EV_FAULT = 0;
  localparam int EV_SW = 1;
  localparam int EV_WDT = 2;
  localparam int EV_EXT = 3;
  localparam int EV_W = 4;

  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0] RESET_HOLD_CYCLES = 8'h10;
  localparam logic [7:0] TA_WINDOW_CYCLES = 8'h08;

  typedef enum logic [1:0] {RSB_RUN, RSB_HOLD} rsb_state_e;
  typedef enum logic [1:0] {RSB_CAUSE_EXT, RSB_CAUSE_WDT, RSB_CAUSE_FAULT, RSB_CAUSE_SW}
    rsb_cause_e;
  typedef enum logic [2:0] {
    RSB_SEL_NONE, RSB_SEL_CC, RSB_SEL_AX, RSB_SEL_WD, RSB_SEL_CFG, RSB_SEL_TA,
    RSB_SEL_IST, RSB_SEL_IMK
  } rsb_sel_e;

  typedef struct packed {
    rsb_state_e state;
    logic [7:0] hold_cnt;
    rsb_cause_e cause;
    logic sw_trigger;
    logic boot_select;
    logic iap_fail;
    logic iap_enable;
    logic sw_flag;
    logic ext_flag;
    logic fault_flag;
    logic gp_flag;
    logic uart_swap;
    logic dptr_sel;
    logic wd_run;
    logic wd_timeout_flag;
    logic wd_idle_pd;
    logic wd_reset_flag;
    logic [WD_PRESCALE_W-1:0] wd_prescale;
    logic [7:0] config_byte;
    logic ta_armed;
    logic ta_open;
    logic [7:0] ta_cnt;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_mask;
    logic wdt_clear;
    logic [31:0] prdata;
  } rsb_state_s;

endpackage

// [rsb_reset_ctrl_checker.sv]
// Port-level assertions for the reset control block
`timescale 1ns/1ps
module rsb_reset_ctrl_checker
  import rsb_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [7:0] HOLD_CYCLES = RESET_HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic pc_overflow,
  input wire logic debug_running,
  input wire logic wdt_timeout,
  input wire logic ext_pin_reset,
  input wire logic system_reset,
  input wire logic wdt_clear,
  input wire logic boot_from_loader,
  input wire logic [15:0] reset_vector
);
  logic [7:0] hi_q;
  logic wr;
  logic map;
  // Length of the present warm reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= system_reset ? hi_q + 8'h01 : 8'h00;
    end
  end
  // Write strobe and decode
  assign wr = psel && penable && pwrite;
  assign map = paddr inside {IDX_CHIP_CONTROL * 4, IDX_AUX_FLAGS * 4,
    IDX_WATCHDOG_CONTROL * 4, IDX_BOOT_CONFIG * 4, IDX_TIMED_ACCESS * 4,
    IDX_IRQ_STATUS * 4, IDX_IRQ_MASK * 4};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence sw_hit;
    wr && paddr == IDX_CHIP_CONTROL * 4 && pwdata[CC_SW_RESET];
  endsequence
  sequence sw_seq;
    sw_hit ##2 $rose(system_reset);
  endsequence
  wdt_reset_a: assert property (!system_reset && wdt_timeout |=> system_reset)
    else $error("no warm reset after watchdog time-out");
  fault_reset_a: assert property (!system_reset && pc_overflow && !debug_running
    |=> system_reset)
    else $error("no warm reset after flash overrun");
  hold_len_a: assert property ($fell(system_reset) |-> hi_q > HOLD_CYCLES)
    else $error("warm reset too short");
  rise_cause_a: assert property ($rose(system_reset) |->
    $past(wdt_timeout || pc_overflow || ext_pin_reset) || $past(wr && pwdata[CC_SW_RESET]
    && paddr == IDX_CHIP_CONTROL * 4, 2))
    else $error("warm reset without cause");
  vector_zero_a: assert property (reset_vector == RESET_VECTOR)
    else $error("reset vector not zero");
  wdt_clear_a: assert property (wdt_clear |-> $past(wr && pwdata[WD_CLEAR]
    && paddr == IDX_WATCHDOG_CONTROL * 4))
    else $error("watchdog clear without write");
  boot_hold_a: assert property (!system_reset && !$past(system_reset)
    && !$past(wr && paddr == IDX_CHIP_CONTROL * 4) |-> $stable(boot_from_loader))
    else $error("boot select moved while running");
  unmapped_a: assert property (psel && penable && !map |-> pslverr)
    else $error("unmapped access not refused");
  sw_reset_c: cover property (sw_seq);
endmodule

bind rsb_reset_ctrl rsb_reset_ctrl_checker #(.ADDR_W(ADDR_W), .HOLD_CYCLES(HOLD_CYCLES))
  u_chk (.*);

// [rsb_reset_ctrl_tb.sv]
// Self-checking bench for the reset control block
`timescale 1ns/1ps
module rsb_reset_ctrl_tb
  import rsb_pkg::*;
;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, se;
  logic pc_overflow = 0, debug_running = 0, wdt_timeout = 0, ext_pin_reset = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, system_reset, wdt_clear, boot_from_loader, irq;
  logic [15:0] reset_vector;
  int err_count = 0, n_checks = 0, cyc = 0, clr_n = 0;
  // Index, expected read byte, expected error
  logic [16:0] rows [8] = '{{IDX_CHIP_CONTROL, 8'h00, 1'b0}, {IDX_AUX_FLAGS, 8'h00, 1'b0},
    {IDX_BOOT_CONFIG, 8'hFF, 1'b0}, {IDX_TIMED_ACCESS, 8'h00, 1'b0},
    {IDX_IRQ_STATUS, 8'h00, 1'b0}, {IDX_IRQ_MASK, 8'h00, 1'b0},
    {8'h00, 8'h00, 1'b1}, {8'hC0, 8'h00, 1'b1}};
  rsb_reset_ctrl u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_overflow(pc_overflow), .debug_running(debug_running),
    .wdt_timeout(wdt_timeout), .ext_pin_reset(ext_pin_reset), .system_reset(system_reset),
    .wdt_clear(wdt_clear), .boot_from_loader(boot_from_loader),
    .reset_vector(reset_vector), .irq(irq));
  always #10 clk = ~clk;
  // Cycle ceiling; also counts clear pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdt_clear === 1'b1) clr_n <= clr_n + 1;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task end_of_test;
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One APB transfer; idle edge after it avoids a same-step restart
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd, e);
  endtask
  task unlock;
    apb(1'b1, IDX_TIMED_ACCESS, TA_KEY_FIRST);
    apb(1'b1, IDX_TIMED_ACCESS, TA_KEY_SECOND);
  endtask
  // no power-down entry, so no divided-clock hazard
  // Waits for a warm reset to come and go
  task warm;
    int n;
    n = 0;
    while (system_reset !== 1'b1 && n < 4) begin
      @(posedge clk);
      n++;
    end
    chk(system_reset, 32'h1);
    n = 0;
    while (system_reset !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(system_reset, 32'h0);
    @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Reset values and unmapped refusal
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, rows[k][16:9], 8'h00);
      chk(rd, {24'h0, rows[k][8:1]});
      chk(se, rows[k][0]);
    end
    apb(1'b1, IDX_IRQ_MASK, 8'h0F);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    warm();
    chk(irq, 32'h1);
    unlock();
    apb(1'b1, IDX_WATCHDOG_CONTROL, 8'h48);
    // Let the pulse counter settle before looking at it
    @(posedge clk);
    chk(clr_n, 32'h1);
    rdc(IDX_WATCHDOG_CONTROL, 32'h08);
    debug_running <= 1'b1;
    pc_overflow <= 1'b1;
    @(posedge clk);
    pc_overflow <= 1'b0;
    warm();
    rdc(IDX_AUX_FLAGS, 32'h20);
    apb(1'b1, IDX_AUX_FLAGS, 8'h00);
    rdc(IDX_AUX_FLAGS, 32'h00);
    apb(1'b1, IDX_BOOT_CONFIG, 8'h6F);
    pc_overflow <= 1'b1;
    @(posedge clk);
    pc_overflow <= 1'b0;
    repeat (4) @(posedge clk);
    chk(system_reset, 32'h0);
    rdc(IDX_AUX_FLAGS, 32'h20);
    chk(boot_from_loader, 32'h0);
    ext_pin_reset <= 1'b1;
    @(posedge clk);
    ext_pin_reset <= 1'b0;
    warm();
    chk(boot_from_loader, 32'h1);
    rdc(IDX_AUX_FLAGS, 32'h60);
    apb(1'b1, IDX_CHIP_CONTROL, 8'h80);
    repeat (4) @(posedge clk);
    chk(system_reset, 32'h0);
    rdc(IDX_CHIP_CONTROL, 32'h02);
    apb(1'b1, IDX_BOOT_CONFIG, 8'hFF);
    unlock();
    apb(1'b1, IDX_CHIP_CONTROL, 8'h82);
    warm();
    chk(boot_from_loader, 32'h1);
    rdc(IDX_CHIP_CONTROL, 32'h02);
    rdc(IDX_AUX_FLAGS, 32'hE0);
    apb(1'b1, IDX_IRQ_MASK, 8'h00);
    chk(irq, 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 8'h0F);
    chk(irq, 32'h1);
    apb(1'b1, IDX_IRQ_STATUS, 8'h0F);
    chk(irq, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(IDX_AUX_FLAGS, 32'h00);
    chk(boot_from_loader, 32'h0);
    apb(1'b0, IDX_WATCHDOG_CONTROL, 8'h00);
    chk(rd & 32'h08, 32'h0);
    end_of_test();
  end
endmodule
